// File: core/i2css_top.sv
// I2C slave status flags, address mask matching and APB register file
//
// Design decisions made here: the register addresses and register access over APB.
`default_nettype none
module i2css_top (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // I2C bus pins
    input  wire logic        scl_i,
    input  wire logic        sda_i,
    output logic             sda_o,
    output logic             sda_oe,
    // Interrupt
    output logic             irq
);

    // ****************************************
    // Declarations
    // ****************************************
    logic [1:0]                  pins_s;
    i2css_pkg::i2css_line_t      ev;
    i2css_pkg::i2css_state_t     state_r;
    logic [3:0]                  cnt_r;
    logic [7:0]                  rx_shift_r;
    logic [7:0]                  tx_shift_r;
    logic [7:0]                  rcv_r;
    logic [7:0]                  txd_r;
    logic [9:0]                  mask_r;
    logic [9:0]                  own_r;
    logic                        en_r;
    logic                        start_flag_r;
    logic                        dir_r;
    logic                        rbf_r;
    logic                        tbf_r;
    logic                        ack_r;
    logic [3:0]                  irq_stat_r;
    logic [3:0]                  irq_mask_r;
    logic [3:0]                  irq_set;
    logic [31:0]                 rdata_nxt;
    logic                        wr_acc;
    logic                        rd_acc;
    logic                        addr_done;
    logic                        addr_hit;
    logic                        rx_done;
    logic                        tx_done;
    logic                        mapped;

    // ****************************************
    // Helpers
    // ****************************************
    // True when a register sits at this offset
    function automatic logic is_mapped(input logic [7:0] a);
        is_mapped = (a == i2css_pkg::OFS_CONTROL)    || (a == i2css_pkg::OFS_BUS_STATUS) ||
                    (a == i2css_pkg::OFS_ADDR_MASK)  || (a == i2css_pkg::OFS_RX_HOLD)    ||
                    (a == i2css_pkg::OFS_TX_REG)     || (a == i2css_pkg::OFS_OWN_ADDR)   ||
                    (a == i2css_pkg::OFS_IRQ_STATUS) || (a == i2css_pkg::OFS_IRQ_MASK);
    endfunction

    // Address compare with masked positions ignored
    function automatic logic addr_match(input logic [6:0] rx, input logic [6:0] own,
                                        input logic [6:0] msk);
        addr_match = ((rx ^ own) & ~msk) == 7'h00;
    endfunction

    // ****************************************
    // Pin synchronisers and line events
    // ****************************************
    i2css_sync #(
        .W       (2)
    ) u_sync (
        .pclk    (pclk),
        .presetn (presetn),
        .d_in    ({scl_i, sda_i}),
        .d_out   (pins_s)
    );

    i2css_cond u_cond (
        .pclk    (pclk),
        .presetn (presetn),
        .scl_s   (pins_s[1]),
        .sda_s   (pins_s[0]),
        .ev      (ev)
    );

    // ****************************************
    // APB access decode
    // ****************************************
    assign mapped  = is_mapped(paddr);
    assign wr_acc  = psel && penable && pwrite && mapped;
    assign rd_acc  = psel && penable && !pwrite && mapped;
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !mapped;

    // ****************************************
    // Bus event terms
    // ****************************************
    assign addr_done = (state_r == i2css_pkg::ST_ADDR) && ev.scl_fall && (cnt_r == i2css_pkg::BITS_PER_BYTE);
    assign addr_hit  = addr_match(rx_shift_r[7:1], own_r[6:0], mask_r[6:0]);
    assign rx_done   = (state_r == i2css_pkg::ST_RX) && ev.scl_fall && (cnt_r == i2css_pkg::BITS_PER_BYTE);
    assign tx_done   = (state_r == i2css_pkg::ST_TX) && ev.scl_fall && (cnt_r == i2css_pkg::BITS_PER_BYTE);

    // ****************************************
    // Slave protocol state
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= i2css_pkg::ST_IDLE;
        end else if (!en_r || ev.stop) begin
            state_r <= i2css_pkg::ST_IDLE;
        end else if (ev.start) begin
            state_r <= i2css_pkg::ST_ADDR;
        end else begin
            case (state_r)
                i2css_pkg::ST_ADDR: begin
                    if (addr_done) begin
                        state_r <= addr_hit ? i2css_pkg::ST_AACK : i2css_pkg::ST_IDLE;
                    end
                end
                i2css_pkg::ST_AACK: begin
                    if (ev.scl_fall) begin
                        state_r <= dir_r ? i2css_pkg::ST_TX : i2css_pkg::ST_RX;
                    end
                end
                i2css_pkg::ST_RX: begin
                    // A byte arriving while the holding register is full is refused
                    if (rx_done) begin
                        state_r <= rbf_r ? i2css_pkg::ST_IDLE : i2css_pkg::ST_RACK;
                    end
                end
                i2css_pkg::ST_RACK: begin
                    if (ev.scl_fall) begin
                        state_r <= i2css_pkg::ST_RX;
                    end
                end
                i2css_pkg::ST_TX: begin
                    if (tx_done) begin
                        state_r <= i2css_pkg::ST_TACK;
                    end
                end
                i2css_pkg::ST_TACK: begin
                    if (ev.scl_fall) begin
                        state_r <= ack_r ? i2css_pkg::ST_TX : i2css_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_r <= i2css_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // ****************************************
    // Bit counter and shifters
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
        end else if (ev.start || addr_done || rx_done || tx_done || ev.scl_fall &&
                     (state_r == i2css_pkg::ST_AACK || state_r == i2css_pkg::ST_RACK ||
                      state_r == i2css_pkg::ST_TACK)) begin
            cnt_r <= 4'h0;
        end else if (ev.scl_rise && (state_r == i2css_pkg::ST_ADDR || state_r == i2css_pkg::ST_RX ||
                                     state_r == i2css_pkg::ST_TX)) begin
            cnt_r <= cnt_r + 4'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_shift_r <= 8'h00;
        end else if (ev.scl_rise && (state_r == i2css_pkg::ST_ADDR || state_r == i2css_pkg::ST_RX)) begin
            rx_shift_r <= {rx_shift_r[6:0], ev.sda};
        end
    end

    // Data changes only on the falling clock so SDA is stable while SCL is high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_shift_r <= 8'hff;
        end else if (ev.scl_fall && (state_r == i2css_pkg::ST_AACK || state_r == i2css_pkg::ST_TACK)) begin
            tx_shift_r <= txd_r;
        end else if (ev.scl_fall && state_r == i2css_pkg::ST_TX && cnt_r != 4'h0) begin
            tx_shift_r <= {tx_shift_r[6:0], 1'b1};
        end
    end

    // Master acknowledge after each sent byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ack_r <= 1'b0;
        end else if (state_r == i2css_pkg::ST_TACK && ev.scl_rise) begin
            ack_r <= !ev.sda;
        end
    end

    // Open-drain: only ever pulls low
    assign sda_o  = 1'b0;
    assign sda_oe = (state_r == i2css_pkg::ST_AACK) || (state_r == i2css_pkg::ST_RACK) ||
                    ((state_r == i2css_pkg::ST_TX) && !tx_shift_r[7]);

    // ****************************************
    // Status flags
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            start_flag_r <= 1'b0;
        end else if (!en_r) begin
            start_flag_r <= 1'b0;
        end else if (ev.start) begin
            start_flag_r <= 1'b1;
        end else if (ev.stop) begin
            start_flag_r <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dir_r <= 1'b0;
        end else if (addr_done && addr_hit) begin
            dir_r <= rx_shift_r[0];
        end
    end

    // Hardware set wins over the software read-clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rbf_r <= 1'b0;
            rcv_r <= 8'h00;
        end else if (rx_done && !rbf_r) begin
            rbf_r <= 1'b1;
            rcv_r <= rx_shift_r;
        end else if (rd_acc && paddr == i2css_pkg::OFS_RX_HOLD) begin
            rbf_r <= 1'b0;
        end
    end

    // A write landing on the byte-end cycle keeps the flag set
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tbf_r <= 1'b0;
            txd_r <= 8'hff;
        end else if (wr_acc && paddr == i2css_pkg::OFS_TX_REG) begin
            tbf_r <= 1'b1;
            txd_r <= pwdata[7:0];
        end else if (tx_done) begin
            tbf_r <= 1'b0;
        end
    end

    // ****************************************
    // Configuration registers
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_r       <= 1'b0;
            mask_r     <= i2css_pkg::MASK_RESET;
            own_r      <= i2css_pkg::OWN_ADDR_RESET;
            irq_mask_r <= 4'h0;
        end else if (wr_acc) begin
            case (paddr)
                i2css_pkg::OFS_CONTROL:   en_r       <= pwdata[i2css_pkg::CTRL_ENABLE_BIT];
                i2css_pkg::OFS_ADDR_MASK: mask_r     <= pwdata[9:0];
                i2css_pkg::OFS_OWN_ADDR:  own_r      <= pwdata[9:0];
                i2css_pkg::OFS_IRQ_MASK:  irq_mask_r <= pwdata[3:0];
                default: begin
                end
            endcase
        end
    end

    // ****************************************
    // Interrupt status, write one to clear
    // ****************************************
    always_comb begin
        irq_set                             = 4'h0;
        irq_set[i2css_pkg::IRQ_MATCH_BIT]   = addr_done && addr_hit;
        irq_set[i2css_pkg::IRQ_RX_BIT]      = rx_done && !rbf_r;
        irq_set[i2css_pkg::IRQ_TX_BIT]      = tx_done;
        irq_set[i2css_pkg::IRQ_STOP_BIT]    = ev.stop && en_r;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat_r <= 4'h0;
        end else if (wr_acc && paddr == i2css_pkg::OFS_IRQ_STATUS) begin
            irq_stat_r <= (irq_stat_r & ~pwdata[3:0]) | irq_set;
        end else begin
            irq_stat_r <= irq_stat_r | irq_set;
        end
    end

    assign irq = |(irq_stat_r & irq_mask_r);

    // ****************************************
    // Read data, captured in the setup phase
    // ****************************************
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        case (paddr)
            i2css_pkg::OFS_CONTROL:    rdata_nxt[0]   = en_r;
            i2css_pkg::OFS_BUS_STATUS: rdata_nxt[3:0] = {start_flag_r, dir_r, rbf_r, tbf_r};
            i2css_pkg::OFS_ADDR_MASK:  rdata_nxt[9:0] = mask_r;
            i2css_pkg::OFS_RX_HOLD:    rdata_nxt[7:0] = rcv_r;
            i2css_pkg::OFS_TX_REG:     rdata_nxt[7:0] = txd_r;
            i2css_pkg::OFS_OWN_ADDR:   rdata_nxt[9:0] = own_r;
            i2css_pkg::OFS_IRQ_STATUS: rdata_nxt[3:0] = irq_stat_r;
            i2css_pkg::OFS_IRQ_MASK:   rdata_nxt[3:0] = irq_mask_r;
            default:                   rdata_nxt      = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata_nxt;
        end
    end

    // ****************************************
    // Checks
    // ****************************************
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    sequence s_addr_hit;
        addr_done && addr_hit;
    endsequence

    chk_start_sets: assert property (en_r && ev.start |=> start_flag_r)
        else $error("start flag not set after start");
    chk_start_disable: assert property (!en_r |=> !start_flag_r)
        else $error("start flag kept while disabled");
    chk_dir_latch: assert property (s_addr_hit |=> dir_r == $past(rx_shift_r[0]) ##1 state_r != i2css_pkg::ST_ADDR)
        else $error("direction flag not taken from address byte");
    chk_rbf_set: assert property (rx_done && !rbf_r |=> rbf_r && rcv_r == $past(rx_shift_r))
        else $error("receive full flag or data missing");
    chk_rbf_quiet: assert property (!rbf_r && !rx_done |=> !rbf_r)
        else $error("receive full flag rose without a byte");
    chk_tbf_hold: assert property (tbf_r && !tx_done |=> tbf_r)
        else $error("transmit full flag dropped early");
    chk_tbf_drop: assert property (tx_done && !(wr_acc && paddr == i2css_pkg::OFS_TX_REG) |=> !tbf_r)
        else $error("transmit full flag stuck after byte");
    chk_mask_miss: assert property (addr_done && !addr_hit && en_r && !ev.stop |=> state_r == i2css_pkg::ST_IDLE)
        else $error("unmatched address accepted");
    chk_mask_upper: assert property (psel && !penable && !pwrite && paddr == i2css_pkg::OFS_ADDR_MASK
                                     |=> prdata[31:10] == 22'h000000)
        else $error("upper mask bits not zero");
    chk_rbf_clear: assert property (rd_acc && paddr == i2css_pkg::OFS_RX_HOLD && !rx_done |=> !rbf_r)
        else $error("receive full flag not cleared by read");

endmodule
`default_nettype wire

// File: core/i2css_pkg.sv
// Shared constants, types and register map of the I2C slave status and mask block
`default_nettype none
package i2css_pkg;

    // ****************************************
    // Register byte offsets
    // ****************************************
    localparam logic [7:0] OFS_CONTROL    = 8'h00;
    localparam logic [7:0] OFS_BUS_STATUS = 8'h04;
    localparam logic [7:0] OFS_ADDR_MASK  = 8'h08;
    localparam logic [7:0] OFS_RX_HOLD    = 8'h0c;
    localparam logic [7:0] OFS_TX_REG     = 8'h10;
    localparam logic [7:0] OFS_OWN_ADDR   = 8'h14;
    localparam logic [7:0] OFS_IRQ_STATUS = 8'h18;
    localparam logic [7:0] OFS_IRQ_MASK   = 8'h1c;

    // ****************************************
    // Field positions and widths
    // ****************************************
    localparam int CTRL_ENABLE_BIT = 0;
    localparam int STAT_START_BIT  = 3;
    localparam int STAT_DIR_BIT    = 2;
    localparam int STAT_RBF_BIT    = 1;
    localparam int STAT_TBF_BIT    = 0;
    localparam int MASK_WIDTH      = 10;
    localparam int ADDR_BITS       = 7;
    localparam int IRQ_WIDTH       = 4;
    localparam int IRQ_MATCH_BIT   = 0;
    localparam int IRQ_RX_BIT      = 1;
    localparam int IRQ_TX_BIT      = 2;
    localparam int IRQ_STOP_BIT    = 3;

    // ****************************************
    // Reset values and counts
    // ****************************************
    localparam logic [9:0] MASK_RESET     = 10'h000;
    localparam logic [9:0] OWN_ADDR_RESET = 10'h000;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // Slave protocol states
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_RX   = 3'b011,
        ST_RACK = 3'b100,
        ST_TX   = 3'b101,
        ST_TACK = 3'b110
    } i2css_state_t;

    // Line events seen on the bus, in the pclk domain
    typedef struct packed {
        logic start;
        logic stop;
        logic scl_rise;
        logic scl_fall;
        logic sda;
    } i2css_line_t;

endpackage
`default_nettype wire

// File: core/i2css_sync.sv
// Two-flop synchroniser for the bus pins
`default_nettype none
module i2css_sync #(
    parameter int W = 2
) (
    // Clock and reset
    input  wire logic         pclk,
    input  wire logic         presetn,
    // Data
    input  wire logic [W-1:0] d_in,
    output logic      [W-1:0] d_out
);

    logic [W-1:0] meta_r;

    // Idle bus is high, so both stages reset high
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            meta_r <= '1;
            d_out  <= '1;
        end else begin
            meta_r <= d_in;
            d_out  <= meta_r;
        end
    end

endmodule
`default_nettype wire

// File: core/i2css_cond.sv
// Start, stop and clock edge detector on synchronised bus lines
`default_nettype none
module i2css_cond (
    // Clock and reset
    input  wire logic               pclk,
    input  wire logic               presetn,
    // Synchronised lines
    input  wire logic               scl_s,
    input  wire logic               sda_s,
    // Events
    output i2css_pkg::i2css_line_t  ev
);

    logic scl_q_r;
    logic sda_q_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_q_r <= 1'b1;
            sda_q_r <= 1'b1;
        end else begin
            scl_q_r <= scl_s;
            sda_q_r <= sda_s;
        end
    end

    // SDA moving while SCL stays high marks start or stop
    always_comb begin
        ev.start    = scl_s && scl_q_r && sda_q_r && !sda_s;
        ev.stop     = scl_s && scl_q_r && !sda_q_r && sda_s;
        ev.scl_rise = scl_s && !scl_q_r;
        ev.scl_fall = !scl_s && scl_q_r;
        ev.sda      = sda_s;
    end

endmodule
`default_nettype wire

// File: sim/i2css_mst.sv
// Bus master model that drives the slave's two link lines
`default_nettype none
module i2css_mst (
    // Link lines, open drain on data
    output logic      scl,
    output logic      sda_low,
    input  wire logic sda
);
    timeunit 1ns;
    timeprecision 1ns;

    // ****************************************
    // Bit and byte level, 400 ns clock period
    // ****************************************
    // Clock rests high between frames, as a pulled-up line does
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end

    // Each call of start, stop, wbyte or rbyte steps 5 ns off the pclk grid, so pin moves never race the synchroniser
    task automatic start();
        #5;
        sda_low = 1'b0;
        #100 scl = 1'b1;
        #200 sda_low = 1'b1;
        #200 scl = 1'b0;
        #100;
    endtask

    task automatic stop();
        #5;
        sda_low = 1'b1;
        #100 scl = 1'b1;
        #200 sda_low = 1'b0;
        #200;
    endtask

    task automatic wbit(input logic b);
        sda_low = ~b;
        #100 scl = 1'b1;
        #200 scl = 1'b0;
        #100;
    endtask

    // Released line reads through the pull-up, so a silent slave gives 1
    task automatic rbit(output logic b);
        sda_low = 1'b0;
        #100 scl = 1'b1;
        #100 b = sda;
        #100 scl = 1'b0;
        #100;
    endtask

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic a;
        #5;
        for (int i = 7; i >= 0; i--) wbit(d[i]);
        rbit(a);
        ack = ~a;
    endtask

    task automatic rbyte(input logic ack, output logic [7:0] d);
        #5;
        for (int i = 7; i >= 0; i--) rbit(d[i]);
        wbit(~ack);
    endtask
endmodule
`default_nettype wire

// File: sim/tb.sv
// Self-checking bench for the slave status flags and address mask
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int LIMIT = 40000;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic        scl, m_low, sda_o, sda_oe, irq, a;
    logic [7:0]  paddr, d;
    logic [31:0] pwdata, prdata, q;
    wire         sda;
    int          failures, comparisons, cycles;

    // Pull-up on data: low while either party pulls
    assign sda = ~m_low & (sda_oe ? sda_o : 1'b1);

    i2css_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .scl_i(scl), .sda_i(sda), .sda_o(sda_o), .sda_oe(sda_oe), .irq(irq));
    i2css_mst mst_u (.scl(scl), .sda_low(m_low), .sda(sda));

    always #25 pclk = ~pclk;

    // ****************************************
    // Shared tasks
    // ****************************************
    task automatic end_of_test();
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask

    always @(posedge pclk) begin
        cycles++;
        if (cycles == LIMIT) begin
            failures++;
            end_of_test();
        end
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Waits for pready however long it takes, bounded by the cycle ceiling
    task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd, output logic [31:0] rd,
                       output logic err);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= ad;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] ad, input logic [31:0] wd);
        logic e;
        apb(1'b1, ad, wd, q, e);
    endtask

    task automatic rd(input logic [7:0] ad);
        logic e;
        apb(1'b0, ad, 32'h0, q, e);
    endtask

    // Flags land three pclk after the line event, so let them settle
    task automatic stat(input logic [3:0] m, input logic [3:0] e);
        repeat (6) @(posedge pclk);
        rd(i2css_pkg::OFS_BUS_STATUS);
        check(q & {28'h0, m}, {28'h0, e});
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_regs();
        logic e;
        rd(i2css_pkg::OFS_ADDR_MASK);
        check(q, 32'h0);
        wr(i2css_pkg::OFS_ADDR_MASK, 32'hffffffff);
        rd(i2css_pkg::OFS_ADDR_MASK);
        check(q, 32'h3ff);
        apb(1'b0, 8'h20, 32'h0, q, e);
        check({q[30:0], e}, 32'h1);
        wr(i2css_pkg::OFS_ADDR_MASK, 32'h0);
        wr(i2css_pkg::OFS_OWN_ADDR, 32'h2a);
        wr(i2css_pkg::OFS_CONTROL, 32'h1);
    endtask

    task automatic t_write();
        wr(i2css_pkg::OFS_IRQ_MASK, 32'h0);
        mst_u.start();
        stat(4'h8, 4'h8);
        mst_u.wbyte(8'h54, a);
        check({31'h0, a}, 32'h1);
        stat(4'h4, 4'h0);
        mst_u.wbyte(8'ha5, a);
        stat(4'h2, 4'h2);
        check({31'h0, irq}, 32'h0);
        wr(i2css_pkg::OFS_IRQ_MASK, 32'h2);
        @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        rd(i2css_pkg::OFS_RX_HOLD);
        check(q, 32'ha5);
        stat(4'h2, 4'h0);
        wr(i2css_pkg::OFS_IRQ_STATUS, 32'hf);
        @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        mst_u.stop();
        stat(4'h8, 4'h0);
    endtask

    task automatic probe(input logic [6:0] ad, input logic exp);
        mst_u.start();
        mst_u.wbyte({ad, 1'b0}, a);
        mst_u.stop();
        check({31'h0, a}, {31'h0, exp});
    endtask

    // Masked bit may differ; a neighbour that is not masked must still match
    task automatic t_mask();
        for (int i = 0; i < 7; i++) begin
            wr(i2css_pkg::OFS_ADDR_MASK, 32'h1 << i);
            probe(7'h2a ^ (7'h1 << i), 1'b1);
            probe(7'h2a ^ (7'h1 << ((i + 1) % 7)), 1'b0);
        end
        wr(i2css_pkg::OFS_ADDR_MASK, 32'h0);
    endtask

    task automatic t_read();
        wr(i2css_pkg::OFS_TX_REG, 32'h3c);
        stat(4'h1, 4'h1);
        mst_u.start();
        mst_u.wbyte({7'h2a, 1'b1}, a);
        check({31'h0, a}, 32'h1);
        stat(4'h4, 4'h4);
        mst_u.rbyte(1'b1, d);
        check({24'h0, d}, 32'h3c);
        stat(4'h1, 4'h0);
        mst_u.rbyte(1'b0, d);
        check({24'h0, d}, 32'h3c);
        mst_u.stop();
    endtask

    task automatic t_disable();
        mst_u.start();
        mst_u.wbyte({7'h2a, 1'b0}, a);
        wr(i2css_pkg::OFS_CONTROL, 32'h0);
        stat(4'h8, 4'h0);
        mst_u.stop();
        wr(i2css_pkg::OFS_CONTROL, 32'h1);
    endtask

    initial begin
        pclk = 1'b0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
        t_regs();
        t_write();
        t_mask();
        t_read();
        t_disable();
        end_of_test();
    end
endmodule
`default_nettype wire
